// file: core/l2c_cfg_top.sv
`timescale 1ns/1ps
module l2c_cfg_top
   import l2c_pkg::*;
#(
   parameter int ADDR_W = 29,
   parameter int QWORD_W = 64
)
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic [15:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [7:0] io_wdata_i,
   output logic [7:0] io_rdata_o,
   output logic l2_enable_o,
   output logic [2:0] second_level_cache_size_o,
   output logic cache_size_valid_o,
   input wire logic cpu_cyc_start_i,
   input wire logic cpu_io_cyc_i,
   output logic next_address_request_o,
   input wire logic fill_valid_i,
   input wire logic [QWORD_W-1:0] fill_data_i,
   output logic fill_ready_o,
   output logic drain_valid_o,
   output logic [QWORD_W-1:0] drain_data_o,
   input wire logic drain_ready_i,
   output logic next_read_ok_o,
   input wire logic post_wr_i,
   input wire logic [ADDR_W-1:0] post_addr_i,
   output logic post_ready_o,
   input wire logic wr_retire_i,
   input wire logic rd_req_i,
   input wire logic [ADDR_W-1:0] rd_addr_i,
   output logic rd_grant_o,
   input wire logic sram_wr_start_i,
   output logic sram_we_o,
   output logic sram_data_oe_n_o,
   input wire logic hbus_start_i,
   output logic hbus_valid_o,
   input wire logic tag_start_i,
   output logic tag_done_o,
   input wire logic burst_start_i,
   output logic burst_done_o,
   output logic seq_busy_o
);
   // ------------------------------------------------------------
   // index / data configuration port
   // ------------------------------------------------------------
   logic [7:0] index_reg;
   logic [7:0] arch0_reg;
   logic [7:0] cache_architecture_1_reg;
   logic [7:0] cache_architecture_2_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic idx_wr;
   logic data_wr;
   logic data_rd;
   logic idx_rd;

   assign idx_wr = io_wr_i && (io_addr_i == IDX_PORT);
   assign data_wr = io_wr_i && (io_addr_i == DATA_PORT);
   assign idx_rd = io_rd_i && (io_addr_i == IDX_PORT);
   assign data_rd = io_rd_i && (io_addr_i == DATA_PORT);

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         index_reg <= 8'h00;
      else if (idx_wr)
         index_reg <= io_wdata_i;
   end

   // reserved bits keep their reset value through the write masks
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         arch0_reg <= ARCH0_RST;
         cache_architecture_1_reg <= ARCH1_RST;
         cache_architecture_2_reg <= ARCH2_RST;
      end
      else if (data_wr)
      begin
         if (index_reg == REG_ARCH0)
            arch0_reg <= (io_wdata_i & ARCH0_WMASK) | (ARCH0_RST & ~ARCH0_WMASK);
         if (index_reg == REG_ARCH1)
            cache_architecture_1_reg <= (io_wdata_i & ARCH1_WMASK)
               | (ARCH1_RST & ~ARCH1_WMASK);
         if (index_reg == REG_ARCH2)
            cache_architecture_2_reg <= (io_wdata_i & ARCH2_WMASK)
               | (ARCH2_RST & ~ARCH2_WMASK);
      end
   end

   always_comb
   begin
      rdata_next = rdata_reg;
      if (idx_rd)
         rdata_next = index_reg;
      else if (data_rd)
      begin
         unique case (index_reg)
            REG_ARCH0: rdata_next = arch0_reg;
            REG_ARCH1: rdata_next = cache_architecture_1_reg;
            REG_ARCH2: rdata_next = cache_architecture_2_reg;
            default: rdata_next = UNMAPPED_RD;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         rdata_reg <= 8'h00;
      else
         rdata_reg <= rdata_next;
   end
   assign io_rdata_o = rdata_reg;

   // ------------------------------------------------------------
   // decoded configuration
   // ------------------------------------------------------------
   logic l2_bit;
   logic l2_active;
   logic [2:0] size_code;
   logic io_nxa_off;
   logic [1:0] lowwater;
   logic raw_en;

   assign l2_bit = arch0_reg[L2_EN_BIT];
   assign size_code = cache_architecture_1_reg[SIZE_LSB +: 3];
   assign io_nxa_off = cache_architecture_1_reg[IO_NXA_BIT];
   assign lowwater = cache_architecture_1_reg[LOWWATER_LSB +: 2];
   assign raw_en = cache_architecture_1_reg[RAW_BIT];
   // undefined size codes leave the cache off rather than guess a size
   assign cache_size_valid_o = (size_code <= SIZE_MAX_CODE);
   assign l2_active = l2_bit && cache_size_valid_o;
   assign l2_enable_o = l2_active;
   assign second_level_cache_size_o = size_code;

   // ------------------------------------------------------------
   // next-address request on io cycles
   // ------------------------------------------------------------
   logic nxa_reg;

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         nxa_reg <= 1'b0;
      else
         nxa_reg <= cpu_cyc_start_i && cpu_io_cyc_i && !io_nxa_off;
   end
   assign next_address_request_o = nxa_reg;

   // ------------------------------------------------------------
   // cache-line read buffer
   // ------------------------------------------------------------
   localparam int PTR_W = $clog2(LINE_QWORDS);
   logic [QWORD_W-1:0] line_mem [LINE_QWORDS];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [PTR_W:0] level_reg;
   logic fill_take;
   logic drain_take;

   assign fill_ready_o = (level_reg != (PTR_W+1)'(LINE_QWORDS));
   assign fill_take = fill_valid_i && fill_ready_o;
   assign drain_valid_o = (level_reg != '0);
   assign drain_take = drain_valid_o && drain_ready_i;
   assign drain_data_o = line_mem[rd_ptr_reg];
   // qwords still to be emptied against the low-water mark; 0 waits for an empty line
   assign next_read_ok_o = (level_reg <= {1'b0, lowwater});

   always_ff @(posedge sys_clk_i)
   begin
      if (fill_take)
         line_mem[wr_ptr_reg] <= fill_data_i;
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         level_reg <= '0;
      end
      else
      begin
         if (fill_take)
            wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
         if (drain_take)
            rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
         if (fill_take && !drain_take)
            level_reg <= level_reg + (PTR_W+1)'(1);
         else if (drain_take && !fill_take)
            level_reg <= level_reg - (PTR_W+1)'(1);
      end
   end

   // ------------------------------------------------------------
   // posted write and read-around-write ordering
   // ------------------------------------------------------------
   logic pw_valid_reg;
   logic [ADDR_W-1:0] pw_addr_reg;
   logic addr_differs;

   assign post_ready_o = !pw_valid_reg || wr_retire_i;
   assign addr_differs = (rd_addr_i != pw_addr_reg);
   assign rd_grant_o = rd_req_i && (!pw_valid_reg || (raw_en && addr_differs));

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         pw_valid_reg <= 1'b0;
         pw_addr_reg <= '0;
      end
      else if (post_wr_i && post_ready_o)
      begin
         pw_valid_reg <= 1'b1;
         pw_addr_reg <= post_addr_i;
      end
      else if (wr_retire_i)
         pw_valid_reg <= 1'b0;
   end

   // ------------------------------------------------------------
   // sram and host bus timing
   // ------------------------------------------------------------
   l2c_timing_if tif ();

   assign tif.host_fast = cache_architecture_2_reg[HOST_SPD_BIT];
   assign tif.we_fast = cache_architecture_2_reg[WEPW_BIT];
   assign tif.hold_drop = cache_architecture_2_reg[HOLD_BIT];
   assign tif.burst_ws = cache_architecture_2_reg[BURST_WS_LSB +: 2];
   assign tif.tag_ws = cache_architecture_2_reg[TAG_WS_LSB +: 2];
   // sram write, tag and burst starts are gated off while the l2 is disabled; host bus starts are not
   assign tif.wr_start = sram_wr_start_i && l2_active;
   assign tif.tag_start = tag_start_i && l2_active;
   assign tif.burst_start = burst_start_i && l2_active;
   assign tif.hbus_start = hbus_start_i;

   l2c_sram_seq l2c_sram_seq_inst (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .tif(tif)
   );

   assign sram_we_o = tif.we;
   assign sram_data_oe_n_o = tif.data_oe_n;
   assign hbus_valid_o = tif.hbus_valid;
   assign tag_done_o = tif.tag_done;
   assign burst_done_o = tif.burst_done;
   assign seq_busy_o = tif.busy;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_nxa_io_gen: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (cpu_cyc_start_i && cpu_io_cyc_i) |=> (next_address_request_o == !$past(io_nxa_off)))
      else $error("next address request wrong for io cycle");
   chk_nxa_other_cyc: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (cpu_cyc_start_i && !cpu_io_cyc_i) |=> !next_address_request_o)
      else $error("next address request on a non io cycle");
   chk_grant_no_post: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (rd_req_i && !pw_valid_reg) |-> rd_grant_o)
      else $error("read held back with no posted write");
   chk_raw_pass: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (rd_req_i && pw_valid_reg && raw_en && addr_differs) |-> rd_grant_o)
      else $error("read not passed around a different address");
   chk_full_refuse: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (level_reg == (PTR_W+1)'(LINE_QWORDS)) |-> !fill_ready_o)
      else $error("fill accepted into a full line buffer");
   chk_drain_stall_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (drain_valid_o && !drain_ready_i) |=> (drain_valid_o && $stable(drain_data_o)))
      else $error("drain data moved while l1 stalled");
   chk_lowwater_full: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (lowwater == 2'h3 && level_reg == (PTR_W+1)'(LINE_QWORDS)) |-> !next_read_ok_o)
      else $error("next read started with a full line left");
   chk_size_undef_off: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (size_code > SIZE_MAX_CODE) |-> !l2_enable_o)
      else $error("cache enabled with an undefined size");
   chk_enable_follows: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (l2_bit && size_code <= SIZE_MAX_CODE) |-> l2_enable_o)
      else $error("cache not enabled when bit set");
   chk_raw_block: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (pw_valid_reg && (!raw_en || !addr_differs)) |-> !rd_grant_o)
      else $error("read passed a posted write");
   chk_lowwater_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (lowwater == 2'h0 && drain_valid_o) |-> !next_read_ok_o)
      else $error("next read before line fully drained");
   chk_disabled_quiet: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (!l2_active && !sram_we_o) |=> !sram_we_o)
      else $error("sram write while cache disabled");
   chk_arch_reset: assert property (@(posedge sys_clk_i)
      $fell(sys_rst_i) |-> (cache_architecture_1_reg == ARCH1_RST
         && cache_architecture_2_reg == ARCH2_RST))
      else $error("architecture registers wrong after reset");
   chk_reserved_keep: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      data_wr |=> (cache_architecture_2_reg[7] && !cache_architecture_1_reg[0]))
      else $error("reserved bit took a write");
endmodule

// file: core/l2c_pkg.sv
package l2c_pkg;
   // io ports and register indexes
   localparam logic [15:0] IDX_PORT = 16'h0022;
   localparam logic [15:0] DATA_PORT = 16'h0023;
   localparam logic [7:0] REG_ARCH0 = 8'h20;
   localparam logic [7:0] REG_ARCH1 = 8'h21;
   localparam logic [7:0] REG_ARCH2 = 8'h22;
   localparam logic [7:0] ARCH0_RST = 8'h00;
   localparam logic [7:0] ARCH1_RST = 8'h00;
   localparam logic [7:0] ARCH2_RST = 8'hff;
   localparam logic [7:0] ARCH0_WMASK = 8'h01;
   localparam logic [7:0] ARCH1_WMASK = 8'hfe;
   localparam logic [7:0] ARCH2_WMASK = 8'h7f;
   localparam logic [7:0] UNMAPPED_RD = 8'hff;
   // field positions
   localparam int L2_EN_BIT = 0;
   localparam int SIZE_LSB = 5;
   localparam int IO_NXA_BIT = 4;
   localparam int LOWWATER_LSB = 2;
   localparam int RAW_BIT = 1;
   localparam int HOST_SPD_BIT = 6;
   localparam int WEPW_BIT = 5;
   localparam int HOLD_BIT = 4;
   localparam int BURST_WS_LSB = 2;
   localparam int TAG_WS_LSB = 0;
   localparam logic [2:0] SIZE_MAX_CODE = 3'h5;
   // timing, in sys_clk ticks; one cache bus clock is two ticks
   localparam logic [3:0] TICKS_PER_CLK = 4'h2;
   localparam logic [3:0] WE_SLOW_TICKS = 4'h3;
   localparam logic [3:0] WE_FAST_TICKS = 4'h2;
   localparam logic [3:0] HOLD_TICKS = 4'h2;
   localparam logic [3:0] HBUS_SLOW_TICKS = 4'h4;
   localparam logic [3:0] HBUS_FAST_TICKS = 4'h2;
   localparam logic [3:0] ACCESS_BASE_TICKS = 4'h2;
   localparam int LINE_QWORDS = 4;
endpackage

// file: core/l2c_timing_if.sv
`timescale 1ns/1ps
interface l2c_timing_if;
   logic host_fast;
   logic we_fast;
   logic hold_drop;
   logic [1:0] burst_ws;
   logic [1:0] tag_ws;
   logic wr_start;
   logic hbus_start;
   logic tag_start;
   logic burst_start;
   logic we;
   logic data_oe_n;
   logic hbus_valid;
   logic tag_done;
   logic burst_done;
   logic busy;
   modport ctl (output host_fast, we_fast, hold_drop, burst_ws, tag_ws, wr_start, hbus_start,
      tag_start, burst_start, input we, data_oe_n, hbus_valid, tag_done, burst_done, busy);
   modport seq (input host_fast, we_fast, hold_drop, burst_ws, tag_ws, wr_start, hbus_start,
      tag_start, burst_start, output we, data_oe_n, hbus_valid, tag_done, burst_done, busy);
endinterface

// file: core/l2c_sram_seq.sv
`timescale 1ns/1ps
module l2c_sram_seq
   import l2c_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   l2c_timing_if.seq tif
);
   // ------------------------------------------------------------
   // access timers: host drive, tag, burst
   // ------------------------------------------------------------
   logic [3:0] len_vec [3];
   logic [2:0] start_vec;
   logic [2:0] done_vec;
   logic [2:0] run_vec;
   logic [3:0] tag_extra;
   logic [3:0] burst_extra;

   assign tag_extra = 4'({2'b00, tif.tag_ws} * TICKS_PER_CLK);
   assign burst_extra = 4'({2'b00, tif.burst_ws} * TICKS_PER_CLK);
   assign len_vec[0] = tif.host_fast ? HBUS_FAST_TICKS : HBUS_SLOW_TICKS;
   assign len_vec[1] = ACCESS_BASE_TICKS + tag_extra;
   assign len_vec[2] = ACCESS_BASE_TICKS + burst_extra;
   assign start_vec = {tif.burst_start, tif.tag_start, tif.hbus_start};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_timer
         logic [3:0] cnt_reg;
         always_ff @(posedge sys_clk_i or posedge sys_rst_i)
         begin
            if (sys_rst_i)
               cnt_reg <= 4'h0;
            else if (start_vec[gi] && cnt_reg == 4'h0)
               cnt_reg <= len_vec[gi];
            else if (cnt_reg != 4'h0)
               cnt_reg <= cnt_reg - 4'h1;
         end
         assign done_vec[gi] = (cnt_reg == 4'h1);
         assign run_vec[gi] = (cnt_reg != 4'h0);
      end
   endgenerate

   assign tif.hbus_valid = done_vec[0];
   assign tif.tag_done = done_vec[1];
   assign tif.burst_done = done_vec[2];

   // ------------------------------------------------------------
   // write enable pulse and data hold
   // ------------------------------------------------------------
   logic [3:0] we_cnt_reg;
   logic [3:0] hold_cnt_reg;
   logic we_end;

   assign we_end = (we_cnt_reg == 4'h1);

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         we_cnt_reg <= 4'h0;
      else if (tif.wr_start && we_cnt_reg == 4'h0 && hold_cnt_reg == 4'h0)
         we_cnt_reg <= tif.we_fast ? WE_FAST_TICKS : WE_SLOW_TICKS;
      else if (we_cnt_reg != 4'h0)
         we_cnt_reg <= we_cnt_reg - 4'h1;
   end

   // hold restarts the data phase only after the pulse, so data never outruns we
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         hold_cnt_reg <= 4'h0;
      else if (we_end && !tif.hold_drop)
         hold_cnt_reg <= HOLD_TICKS;
      else if (hold_cnt_reg != 4'h0)
         hold_cnt_reg <= hold_cnt_reg - 4'h1;
   end

   assign tif.we = (we_cnt_reg != 4'h0);
   assign tif.data_oe_n = !(tif.we || hold_cnt_reg != 4'h0);
   assign tif.busy = tif.we || (hold_cnt_reg != 4'h0) || (|run_vec);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_we_slow_width: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      ($rose(tif.we) && !$past(tif.we_fast)) |-> tif.we [*3] ##1 !tif.we)
      else $error("slow write enable not three ticks");
   chk_we_fast_width: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      ($rose(tif.we) && $past(tif.we_fast)) |-> tif.we [*2] ##1 !tif.we)
      else $error("fast write enable not two ticks");
   chk_data_hold_time: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      ($fell(tif.we) && !$past(tif.hold_drop)) |-> !tif.data_oe_n [*2] ##1 tif.data_oe_n)
      else $error("write data not held one extra clock");
   chk_data_drop_edge: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      ($fell(tif.we) && $past(tif.hold_drop)) |-> tif.data_oe_n)
      else $error("write data kept past we edge");
   chk_host_slow_drive: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (tif.hbus_start && !tif.host_fast && !run_vec[0])
         |-> !tif.hbus_valid [*4] ##1 tif.hbus_valid)
      else $error("slow host drive not two clocks");
   chk_tag_wait_len: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (tif.tag_start && tif.tag_ws == 2'h3 && !run_vec[1]) |-> ##8 tif.tag_done)
      else $error("tag wait code three not three clocks slower");
endmodule

// file: verification/l2c_l1_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// l1 side sink of the read buffer drain
// ----------------------------------------
module l2c_l1_model
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic stall_i,
   input wire logic drain_valid_i,
   input wire logic [63:0] drain_data_i,
   output logic drain_ready_o,
   output logic [3:0] got_cnt_o
);
   logic [63:0] got_mem [0:15];
   // a stalled l1 never signals ready, so the buffer must hold its data
   assign drain_ready_o = ~stall_i;
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         got_cnt_o <= 4'h0;
      else if (drain_valid_i && drain_ready_o)
      begin
         got_mem[got_cnt_o] <= drain_data_i;
         got_cnt_o <= got_cnt_o + 4'h1;
      end
   end
endmodule

// file: verification/tb_l2c_cfg_top.sv
`timescale 1ns/1ps
module tb_l2c_cfg_top
   import l2c_pkg::*;
;
   logic sys_clk, sys_rst, io_wr, io_rd, l2_en, size_ok, cyc_start, io_cyc, nxa_req;
   logic [15:0] io_addr;
   logic [7:0] io_wdata, io_rdata;
   logic [2:0] size;
   logic fill_valid, fill_ready, drain_valid, drain_ready, nr_ok, stall;
   logic [63:0] fill_data, drain_data;
   logic post_wr, post_ready, retire, rd_req, rd_grant;
   logic [28:0] post_addr, rd_addr;
   logic [3:0] st, dn, got_cnt;
   logic we, oe_n, hbus_valid, tag_done, burst_done, busy;
   int n_mismatch = 0;
   int num_checks = 0;
   int i, k, n, a, b, p;
   logic hs, wp, dhold;
   localparam logic [63:0] BASE = 64'h0123_4567_89ab_cd00;
   assign dn = {burst_done, tag_done, hbus_valid, 1'b0};
   l2c_cfg_top l2c_cfg_top_inst (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .io_addr_i(io_addr),
      .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
      .l2_enable_o(l2_en), .second_level_cache_size_o(size), .cache_size_valid_o(size_ok),
      .cpu_cyc_start_i(cyc_start), .cpu_io_cyc_i(io_cyc), .next_address_request_o(nxa_req),
      .fill_valid_i(fill_valid), .fill_data_i(fill_data), .fill_ready_o(fill_ready),
      .drain_valid_o(drain_valid), .drain_data_o(drain_data), .drain_ready_i(drain_ready),
      .next_read_ok_o(nr_ok), .post_wr_i(post_wr), .post_addr_i(post_addr),
      .post_ready_o(post_ready), .wr_retire_i(retire), .rd_req_i(rd_req), .rd_addr_i(rd_addr),
      .rd_grant_o(rd_grant), .sram_wr_start_i(st[0]), .sram_we_o(we),
      .sram_data_oe_n_o(oe_n), .hbus_start_i(st[1]), .hbus_valid_o(hbus_valid),
      .tag_start_i(st[2]), .tag_done_o(tag_done), .burst_start_i(st[3]),
      .burst_done_o(burst_done), .seq_busy_o(busy));
   l2c_l1_model l2c_l1_model_inst (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .stall_i(stall),
      .drain_valid_i(drain_valid), .drain_data_i(drain_data), .drain_ready_o(drain_ready),
      .got_cnt_o(got_cnt));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task results;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task ck(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task io_acc(input logic [15:0] ad, input logic [7:0] d, input logic rd);
      @(posedge sys_clk);
      io_addr <= ad;
      io_wdata <= d;
      io_wr <= ~rd;
      io_rd <= rd;
      @(posedge sys_clk);
      io_wr <= 1'b0;
      io_rd <= 1'b0;
      io_wdata <= ~d;
   endtask
   task wr_reg(input logic [7:0] idx, input logic [7:0] v);
      io_acc(IDX_PORT, idx, 1'b0);
      io_acc(DATA_PORT, v, 1'b0);
      #1;
   endtask
   task rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      io_acc(IDX_PORT, idx, 1'b0);
      io_acc(DATA_PORT, 8'h00, 1'b1);
      #1;
      ck(io_rdata, exp);
   endtask
   task fill(input logic [63:0] d);
      @(posedge sys_clk);
      fill_valid <= 1'b1;
      fill_data <= d;
      @(posedge sys_clk);
      fill_valid <= 1'b0;
      fill_data <= ~d;
   endtask
   // pulse one start, then watch 16 cycles: we and oe widths, first done position
   task seq_run(input int sel, output int we_n, output int oe_n_n, output int pos);
      int j;
      @(posedge sys_clk);
      st[sel] <= 1'b1;
      @(posedge sys_clk);
      st <= 4'h0;
      we_n = 0;
      oe_n_n = 0;
      pos = 0;
      for (j = 1; j <= 16; j++)
      begin
         @(negedge sys_clk);
         if (we === 1'b1) we_n++;
         if (oe_n === 1'b0) oe_n_n++;
         if (pos == 0 && dn[sel] === 1'b1) pos = j;
      end
   endtask
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // run is about 500 cycles; a hang is cut off well past that
   initial
   begin
      #100000;
      n_mismatch++;
      results;
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      {io_wr, io_rd, cyc_start, io_cyc, fill_valid, post_wr, retire, rd_req} = 8'h00;
      {io_addr, io_wdata, fill_data, post_addr, rd_addr, st} = '0;
      stall = 1'b1;
      sys_rst = 1'b1;
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd_chk(REG_ARCH0, 8'h00);
      rd_chk(REG_ARCH1, 8'h00);
      rd_chk(REG_ARCH2, 8'hff);
      rd_chk(8'h3c, UNMAPPED_RD);
      wr_reg(REG_ARCH1, 8'hff);
      rd_chk(REG_ARCH1, 8'hfe);
      wr_reg(REG_ARCH2, 8'h00);
      rd_chk(REG_ARCH2, 8'h80);
      $display("test registers done");
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd_chk(REG_ARCH1, ARCH1_RST);
      rd_chk(REG_ARCH2, ARCH2_RST);
      $display("test mid-run reset done");
      wr_reg(REG_ARCH0, 8'h01);
      for (i = 0; i < 8; i++)
      begin
         wr_reg(REG_ARCH1, 8'(i << 5));
         ck(size, i);
         ck(size_ok, i <= 5);
         ck(l2_en, i <= 5);
      end
      wr_reg(REG_ARCH1, 8'h00);
      wr_reg(REG_ARCH0, 8'h00);
      ck(l2_en, 0);
      wr_reg(REG_ARCH0, 8'h01);
      ck(l2_en, 1);
      $display("test size and enable done");
      for (i = 0; i < 3; i++)
      begin
         wr_reg(REG_ARCH1, (i == 1) ? 8'h10 : 8'h00);
         @(posedge sys_clk);
         cyc_start <= 1'b1;
         io_cyc <= (i != 2);
         @(posedge sys_clk);
         cyc_start <= 1'b0;
         n = 0;
         repeat (3) @(negedge sys_clk) if (nxa_req === 1'b1) n++;
         ck(n, i == 0);
      end
      $display("test next address done");
      for (k = 0; k < 3; k++) fill(BASE + k);
      for (i = 0; i < 4; i++)
      begin
         wr_reg(REG_ARCH1, 8'(i << 2));
         ck(nr_ok, i >= 3);
      end
      ck(drain_valid, 1);
      ck(drain_data, BASE);
      fill(BASE + 3);
      #1;
      ck(fill_ready, 0);
      @(posedge sys_clk);
      stall <= 1'b0;
      for (k = 0; k < 20 && got_cnt !== 4'h4; k++) @(posedge sys_clk);
      #1;
      ck(got_cnt, 4);
      for (k = 0; k < 4; k++) ck(l2c_l1_model_inst.got_mem[k], BASE + k);
      ck(drain_valid, 0);
      wr_reg(REG_ARCH1, 8'h00);
      ck(nr_ok, 1);
      $display("test read buffer done");
      @(posedge sys_clk);
      post_wr <= 1'b1;
      post_addr <= 29'h100;
      rd_req <= 1'b1;
      rd_addr <= 29'h200;
      @(posedge sys_clk);
      post_wr <= 1'b0;
      post_addr <= ~29'h100;
      #1;
      ck(post_ready, 0);
      ck(rd_grant, 0);
      wr_reg(REG_ARCH1, 8'h02);
      ck(rd_grant, 1);
      @(posedge sys_clk);
      rd_addr <= 29'h100;
      #1;
      ck(rd_grant, 0);
      @(posedge sys_clk);
      retire <= 1'b1;
      @(posedge sys_clk);
      retire <= 1'b0;
      #1;
      ck(rd_grant, 1);
      ck(post_ready, 1);
      @(posedge sys_clk);
      rd_req <= 1'b0;
      $display("test read around write done");
      wr_reg(REG_ARCH0, 8'h00);
      seq_run(2, a, b, p);
      ck(p, 0);
      wr_reg(REG_ARCH0, 8'h01);
      for (i = 0; i < 4; i++)
      begin
         hs = i[0];
         wp = (i == 1 || i == 2);
         dhold = (i != 1);
         wr_reg(REG_ARCH2, {1'b0, hs, wp, dhold, i[1:0], ~i[1:0]});
         seq_run(0, a, b, p);
         ck(a, wp ? 2 : 3);
         ck(b, (wp ? 2 : 3) + (dhold ? 0 : 2));
         seq_run(1, a, b, p);
         ck(p, hs ? 2 : 4);
         seq_run(2, a, b, p);
         ck(p, 2 + 2 * (3 - i));
         seq_run(3, a, b, p);
         ck(p, 2 + 2 * i);
      end
      ck(busy, 0);
      $display("test sequencer done");
      results;
   end
endmodule
